// file: reset_strap_config_decoder.sv
// Purpose: capture configuration straps at reset release and decode defaults
// Assumes: rom check result arrives from the rom reader after release
// Notes: straps are frozen from the third edge after reset until the next reset
`timescale 1ns/10ps
module reset_strap_config_decoder (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [2:0] rom_data_out_lvl_i,
	input wire logic [2:0] rom_clock_lvl_i,
	input wire logic [2:0] fixed_port_setting_i,
	input wire logic [2:0] charge_port_setting_i,
	input wire logic [2:0] shared_function_pins_i,
	input wire logic [3:0] port_plus_line_disable_i,
	input wire logic [3:0] port_minus_line_disable_i,
	input wire logic rom_check_done_i,
	input wire logic [15:0] rom_sig_addr_i,
	input wire logic [31:0] rom_sig_word_i,
	output logic cfg_valid_o,
	output logic [1:0] pin_mode_o,
	output logic [2:0] profile_o,
	output logic [3:0] port2_disable_o,
	output logic [3:0] port3_disable_o,
	output logic [3:0] fixed_port_mask_o,
	output logic [3:0] charge_port_mask_o,
	output logic smbus_slave_en_o,
	output logic i2c_bridge_en_o,
	output logic uart_en_o,
	output logic rom_en_o,
	output logic smbus_pins_en_o,
	output logic [1:0] host_port_select_o
);
	// edges during which the synchroniser still shows its reset value
	localparam int SETTLE_CYCLES = 2;
	localparam int SETTLE_W = 2;

	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_CAPTURE,
		ST_ROM_WAIT,
		ST_DONE
	} state_t;

	strap_cfg_pkg::strap_raw_t raw_sync;
	strap_cfg_pkg::strap_raw_t raw_reg;
	strap_cfg_pkg::strap_raw_t raw_next;
	strap_cfg_pkg::strap_cfg_t cfg_reg;
	strap_cfg_pkg::strap_cfg_t cfg_next;
	state_t state_reg;
	state_t state_next;
	logic valid_reg;
	logic valid_next;
	logic [1:0] host_sel_reg;
	logic [1:0] host_sel_next;
	logic [SETTLE_W-1:0] settle_reg;
	logic [SETTLE_W-1:0] settle_next;
	logic capture_now;
	logic rom_result_now;
	logic rom_sig_good;
	strap_cfg_pkg::pin_mode_t strap_mode;

	// straps come from pins: two flops before use
	strap_sync #(
		.WIDTH($bits(strap_cfg_pkg::strap_raw_t))
	) u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({rom_data_out_lvl_i, rom_clock_lvl_i, fixed_port_setting_i, charge_port_setting_i,
			shared_function_pins_i, port_plus_line_disable_i, port_minus_line_disable_i}),
		.q_o(raw_sync)
	);

	// level code to a thermometer mask from port 1 upward
	function automatic logic [3:0] count_mask(input logic [2:0] lvl);
		case (lvl)
			strap_cfg_pkg::LVL_200K_DN: count_mask = 4'h0;
			strap_cfg_pkg::LVL_200K_UP: count_mask = 4'h1;
			strap_cfg_pkg::LVL_10K_DN: count_mask = 4'h3;
			strap_cfg_pkg::LVL_10K_UP: count_mask = 4'h7;
			strap_cfg_pkg::LVL_10R_DN: count_mask = 4'hf;
			default: count_mask = 4'h0;
		endcase
	endfunction

	function automatic logic [2:0] decode_profile(input logic [2:0] lvl);
		case (lvl)
			strap_cfg_pkg::LVL_200K_DN: decode_profile = 3'h1;
			strap_cfg_pkg::LVL_200K_UP: decode_profile = 3'h2;
			strap_cfg_pkg::LVL_10K_DN: decode_profile = 3'h3;
			strap_cfg_pkg::LVL_10K_UP: decode_profile = 3'h4;
			strap_cfg_pkg::LVL_10R_DN: decode_profile = 3'h5;
			strap_cfg_pkg::LVL_10R_UP: decode_profile = 3'h6;
			default: decode_profile = strap_cfg_pkg::PROFILE_DEFAULT;
		endcase
	endfunction

	// profiles that route smbus data and clock onto pins four and five
	function automatic logic profile_has_smbus(input logic [2:0] prof);
		profile_has_smbus = (prof == 3'h1) || (prof == 3'h2) || (prof == 3'h3) || (prof == 3'h6);
	endfunction

	function automatic logic is_pull_up(input logic [2:0] lvl);
		is_pull_up = (lvl == strap_cfg_pkg::LVL_10K_UP) || (lvl == strap_cfg_pkg::LVL_200K_UP)
			|| (lvl == strap_cfg_pkg::LVL_10R_UP);
	endfunction

	function automatic logic is_pull_down(input logic [2:0] lvl);
		is_pull_down = (lvl == strap_cfg_pkg::LVL_10K_DN) || (lvl == strap_cfg_pkg::LVL_200K_DN)
			|| (lvl == strap_cfg_pkg::LVL_10R_DN);
	endfunction

	// serial pin mode from data-out and clock straps; both pulled up beats uart
	function automatic strap_cfg_pkg::pin_mode_t select_mode(input logic [2:0] data_lvl,
		input logic [2:0] clock_lvl);
		if (is_pull_up(data_lvl) && is_pull_up(clock_lvl)) begin
			select_mode = strap_cfg_pkg::MODE_SMBUS;
		end else if (is_pull_down(data_lvl)) begin
			select_mode = strap_cfg_pkg::MODE_UART;
		end else begin
			select_mode = strap_cfg_pkg::MODE_ROM;
		end
	endfunction

	// derive enables from a mode and profile, keeping pairs exclusive
	function automatic strap_cfg_pkg::strap_cfg_t apply_mode(input strap_cfg_pkg::strap_cfg_t c,
		input strap_cfg_pkg::pin_mode_t m);
		strap_cfg_pkg::strap_cfg_t r;
		logic pins_ok;
		r = c;
		pins_ok = profile_has_smbus(c.profile);
		r.pin_mode = m;
		r.smbus_pins_en = pins_ok;
		r.rom_en = (m == strap_cfg_pkg::MODE_ROM);
		r.uart_en = (m == strap_cfg_pkg::MODE_UART);
		r.smbus_slave_en = (m == strap_cfg_pkg::MODE_SMBUS) && pins_ok;
		r.i2c_bridge_en = (m == strap_cfg_pkg::MODE_I2C) && pins_ok;
		apply_mode = r;
	endfunction

	assign strap_mode = select_mode(raw_sync.rom_data_out_lvl, raw_sync.rom_clock_lvl);
	assign rom_sig_good = (rom_sig_addr_i == strap_cfg_pkg::SIG_ADDR)
		&& (rom_sig_word_i == strap_cfg_pkg::SIG_WORD);

	// sequencing: let the synchroniser fill, capture once, wait for the rom result
	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		capture_now = 1'b0;
		rom_result_now = 1'b0;
		case (state_reg)
			ST_SETTLE: begin
				// synchroniser output still holds its reset value
				settle_next = settle_reg + SETTLE_W'(1);
				if (settle_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
					state_next = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				capture_now = 1'b1;
				if (strap_mode == strap_cfg_pkg::MODE_ROM) begin
					state_next = ST_ROM_WAIT;
				end else begin
					state_next = ST_DONE;
				end
			end
			ST_ROM_WAIT: begin
				// rom result ignored in every other state
				if (rom_check_done_i) begin
					rom_result_now = 1'b1;
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_DONE;
			end
			default: begin
				state_next = ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_SETTLE;
			settle_reg <= '0;
		end else begin
			state_reg <= state_next;
			settle_reg <= settle_next;
		end
	end

	// raw strap image kept for the fallback decode
	always_comb begin
		raw_next = raw_reg;
		if (capture_now) begin
			raw_next = raw_sync;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			raw_reg <= '0;
		end else begin
			raw_reg <= raw_next;
		end
	end

	// decoded configuration and its valid flag
	always_comb begin
		cfg_next = cfg_reg;
		valid_next = valid_reg;
		if (capture_now) begin
			cfg_next.profile = decode_profile(raw_sync.shared_function_pins);
			cfg_next.port2_disable = raw_sync.port_plus_line_disable & raw_sync.port_minus_line_disable;
			cfg_next.port3_disable = cfg_next.port2_disable;
			cfg_next.fixed_port_mask = count_mask(raw_sync.fixed_port_setting);
			cfg_next.charge_port_mask = count_mask(raw_sync.charge_port_setting);
			case (strap_mode)
				strap_cfg_pkg::MODE_SMBUS: begin
					cfg_next = apply_mode(cfg_next, strap_cfg_pkg::MODE_SMBUS);
					valid_next = 1'b1;
				end
				strap_cfg_pkg::MODE_UART: begin
					cfg_next = apply_mode(cfg_next, strap_cfg_pkg::MODE_UART);
					valid_next = 1'b1;
				end
				default: begin
					cfg_next = apply_mode(cfg_next, strap_cfg_pkg::MODE_ROM);
					// those strap pins belong to the rom for now
					cfg_next.fixed_port_mask = 4'(strap_cfg_pkg::COUNT_DEFAULT);
					cfg_next.charge_port_mask = 4'(strap_cfg_pkg::COUNT_DEFAULT);
				end
			endcase
		end
		if (rom_result_now) begin
			if (!rom_sig_good) begin
				cfg_next = apply_mode(cfg_next, strap_cfg_pkg::MODE_I2C);
				cfg_next.fixed_port_mask = count_mask(raw_reg.fixed_port_setting);
				cfg_next.charge_port_mask = count_mask(raw_reg.charge_port_setting);
			end
			valid_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			valid_reg <= valid_next;
		end
	end

	// host port select straps, live only in smbus mode
	always_comb begin
		host_sel_next = host_sel_reg;
		if (capture_now && (strap_mode == strap_cfg_pkg::MODE_SMBUS)) begin
			host_sel_next = {is_pull_up(raw_sync.rom_clock_lvl), is_pull_up(raw_sync.rom_data_out_lvl)};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			host_sel_reg <= 2'h0;
		end else begin
			host_sel_reg <= host_sel_next;
		end
	end

	assign cfg_valid_o = valid_reg;
	assign pin_mode_o = cfg_reg.pin_mode;
	assign profile_o = cfg_reg.profile;
	assign port2_disable_o = cfg_reg.port2_disable;
	assign port3_disable_o = cfg_reg.port3_disable;
	assign fixed_port_mask_o = cfg_reg.fixed_port_mask;
	assign charge_port_mask_o = cfg_reg.charge_port_mask;
	assign smbus_slave_en_o = cfg_reg.smbus_slave_en;
	assign i2c_bridge_en_o = cfg_reg.i2c_bridge_en;
	assign uart_en_o = cfg_reg.uart_en;
	assign rom_en_o = cfg_reg.rom_en;
	assign smbus_pins_en_o = cfg_reg.smbus_pins_en;
	assign host_port_select_o = host_sel_reg;
endmodule

// file: strap_cfg_pkg.sv
// Purpose: shared constants and types for the reset strap configuration decoder
// Assumes: resistor straps arrive as level codes from an analog sensing front end
// Notes: level codes below are the front end's encoding
// Notes on behaviour
// - sample all straps during power-on or reset (code holds the synchroniser in reset and samples only after release)
// - latch straps at reset release, hold
// - data-out and clock pulled up: smbus
// - data-out pulled down selects uart mode
// - no pulls selects serial rom first
// - invalid rom falls back to i2c bridge
// - rom valid only with signature at address
// - forbidden mode pairs never enabled together
// - smbus slave only in profiles 1,2,3,6
// - profiles 1,2,3,6 give smbus pins
// - shared pins double as straps per mode
// - line disable straps: 0 enabled, 1 disabled
// - port disabled only when both lines high
// - usb2 disable also disables usb3 side
// - fixed port level gives count from port 1
// - charge port level gives count from port 1
// - profile strap six levels give profiles 1-6
package strap_cfg_pkg;
	localparam int NUM_PORTS = 4;
	localparam int LVL_W = 3;
	// resistor level codes from the sensing front end
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [2:0] LVL_200K_DN = 3'h1;
	localparam logic [2:0] LVL_200K_UP = 3'h2;
	localparam logic [2:0] LVL_10K_DN = 3'h3;
	localparam logic [2:0] LVL_10K_UP = 3'h4;
	localparam logic [2:0] LVL_10R_DN = 3'h5;
	localparam logic [2:0] LVL_10R_UP = 3'h6;
	// firmware-upgrade signature and its start byte address
	localparam logic [15:0] SIG_ADDR = 16'hfffa;
	localparam logic [31:0] SIG_WORD = 32'h32444655;
	localparam logic [2:0] PROFILE_DEFAULT = 3'h1;
	localparam logic [2:0] COUNT_DEFAULT = 3'h0;

	typedef enum logic [1:0] {
		MODE_ROM,
		MODE_SMBUS,
		MODE_I2C,
		MODE_UART
	} pin_mode_t;

	typedef struct packed {
		logic [2:0] rom_data_out_lvl;
		logic [2:0] rom_clock_lvl;
		logic [2:0] fixed_port_setting;
		logic [2:0] charge_port_setting;
		logic [2:0] shared_function_pins;
		logic [3:0] port_plus_line_disable;
		logic [3:0] port_minus_line_disable;
	} strap_raw_t;

	typedef struct packed {
		pin_mode_t pin_mode;
		logic [2:0] profile;
		logic [3:0] port2_disable;
		logic [3:0] port3_disable;
		logic [3:0] fixed_port_mask;
		logic [3:0] charge_port_mask;
		logic smbus_slave_en;
		logic i2c_bridge_en;
		logic uart_en;
		logic rom_en;
		logic smbus_pins_en;
		logic [1:0] host_port_select;
	} strap_cfg_t;
endpackage

// file: strap_sync.sv
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs are quasi-static straps
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module strap_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg <= meta_reg;
		end
	end

	assign q_o = q_reg;
endmodule

// file: reset_strap_config_decoder_assertions.sv
// Purpose: port assertions for the strap decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/10ps
module reset_strap_config_decoder_assertions (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic rom_check_done_i,
	input wire logic cfg_valid_o,
	input wire logic [1:0] pin_mode_o,
	input wire logic [2:0] profile_o,
	input wire logic [3:0] port2_disable_o,
	input wire logic [3:0] port3_disable_o,
	input wire logic [3:0] fixed_port_mask_o,
	input wire logic smbus_slave_en_o,
	input wire logic i2c_bridge_en_o,
	input wire logic uart_en_o,
	input wire logic rom_en_o,
	input wire logic smbus_pins_en_o,
	input wire logic [1:0] host_port_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_excl; $onehot0({smbus_slave_en_o, i2c_bridge_en_o, uart_en_o, rom_en_o}); endproperty
	a_excl: assert property (p_excl) else $error("two pin modes enabled");
	property p_hold; cfg_valid_o |=> cfg_valid_o && $stable({pin_mode_o, profile_o, fixed_port_mask_o}); endproperty
	a_hold: assert property (p_hold) else $error("final setting changed");
	property p_usb3; port3_disable_o == port2_disable_o; endproperty
	a_usb3: assert property (p_usb3) else $error("usb3 disable differs");
	property p_smb; smbus_slave_en_o |-> pin_mode_o == 2'h1 && smbus_pins_en_o; endproperty
	a_smb: assert property (p_smb) else $error("smbus slave without pins");
	property p_pins; cfg_valid_o |-> smbus_pins_en_o == (profile_o inside {3'h1, 3'h2, 3'h3, 3'h6}); endproperty
	a_pins: assert property (p_pins) else $error("smbus pins vs profile");
	property p_rom; rom_en_o && !cfg_valid_o && rom_check_done_i |=> cfg_valid_o && pin_mode_o != 2'h1; endproperty
	a_rom: assert property (p_rom) else $error("rom result not taken");
	property p_therm; cfg_valid_o |-> (fixed_port_mask_o & (fixed_port_mask_o + 4'h1)) == 4'h0; endproperty
	a_therm: assert property (p_therm) else $error("fixed mask not from port 1");
	property p_host; host_port_select_o != 2'h0 |-> pin_mode_o == 2'h1 && !uart_en_o; endproperty
	a_host: assert property (p_host) else $error("host select outside smbus");
	c_smb: cover property (smbus_slave_en_o);
	c_uart: cover property (uart_en_o && cfg_valid_o);
	c_i2c: cover property (i2c_bridge_en_o);
endmodule
bind reset_strap_config_decoder reset_strap_config_decoder_assertions chk_u (.clk_i, .rst_b_i, .rom_check_done_i,
	.cfg_valid_o, .pin_mode_o, .profile_o, .port2_disable_o, .port3_disable_o, .fixed_port_mask_o, .smbus_slave_en_o,
	.i2c_bridge_en_o, .uart_en_o, .rom_en_o, .smbus_pins_en_o, .host_port_select_o);

// file: strap_rom_model.sv
// Purpose: serial rom seen through the rom reader
// Assumes: reader starts once the rom pins are enabled
// Notes: lines toggle outside the result cycle
`timescale 1ns/10ps
module strap_rom_model #(
	parameter int DELAY = 5
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic rom_en_i,
	input wire logic rom_good_i,
	input wire logic rom_addr_good_i,
	output logic rom_check_done_o,
	output logic [15:0] rom_sig_addr_o,
	output logic [31:0] rom_sig_word_o
);
	int cnt;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 0;
			rom_check_done_o <= 1'b0;
			rom_sig_addr_o <= 16'h0;
			rom_sig_word_o <= 32'h0;
		end else begin
			rom_check_done_o <= 1'b0;
			rom_sig_addr_o <= ~rom_sig_addr_o;
			rom_sig_word_o <= ~rom_sig_word_o;
			if (rom_en_i && cnt <= DELAY)
				cnt <= cnt + 1;
			if (rom_en_i && cnt == DELAY) begin
				rom_check_done_o <= 1'b1;
				rom_sig_addr_o <= rom_addr_good_i ? strap_cfg_pkg::SIG_ADDR : ~strap_cfg_pkg::SIG_ADDR;
				rom_sig_word_o <= rom_good_i ? strap_cfg_pkg::SIG_WORD : ~strap_cfg_pkg::SIG_WORD;
			end
		end
	end
endmodule

// file: reset_strap_config_decoder_bench.sv
// Purpose: directed bench for the strap decoder
// Assumes: straps set while reset is low
// Notes: every setting gets its own reset, except the strap change t_smbus makes to check the freeze
`timescale 1ns/10ps
module reset_strap_config_decoder_bench;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic rom_good = 1'b0;
	logic rom_addr_good = 1'b1;
	strap_cfg_pkg::strap_raw_t raw = '0;
	logic rom_done, cfg_valid_o, uart_en_o, rom_en_o, smbus_slave_en_o, i2c_bridge_en_o, smbus_pins_en_o;
	logic [1:0] pin_mode_o, host_port_select_o;
	logic [2:0] profile_o;
	logic [3:0] port2_disable_o, port3_disable_o, fixed_port_mask_o, charge_port_mask_o;
	logic [15:0] sig_addr;
	logic [31:0] sig_word;
	logic [2:0] lv [7] = '{strap_cfg_pkg::LVL_NONE, strap_cfg_pkg::LVL_200K_DN, strap_cfg_pkg::LVL_200K_UP,
		strap_cfg_pkg::LVL_10K_DN, strap_cfg_pkg::LVL_10K_UP, strap_cfg_pkg::LVL_10R_DN, strap_cfg_pkg::LVL_10R_UP};
	int mismatches = 0;
	int n_tests = 0;
	initial forever #12.5 clk_i = ~clk_i;
	reset_strap_config_decoder dut_u (.clk_i, .rst_b_i, .rom_data_out_lvl_i(raw.rom_data_out_lvl),
		.rom_clock_lvl_i(raw.rom_clock_lvl), .fixed_port_setting_i(raw.fixed_port_setting),
		.charge_port_setting_i(raw.charge_port_setting), .shared_function_pins_i(raw.shared_function_pins),
		.port_plus_line_disable_i(raw.port_plus_line_disable), .port_minus_line_disable_i(raw.port_minus_line_disable),
		.rom_check_done_i(rom_done), .rom_sig_addr_i(sig_addr), .rom_sig_word_i(sig_word), .cfg_valid_o, .pin_mode_o,
		.profile_o, .port2_disable_o, .port3_disable_o, .fixed_port_mask_o, .charge_port_mask_o, .smbus_slave_en_o,
		.i2c_bridge_en_o, .uart_en_o, .rom_en_o, .smbus_pins_en_o, .host_port_select_o);
	strap_rom_model rom_u (.clk_i, .rst_b_i, .rom_en_i(rom_en_o), .rom_good_i(rom_good),
		.rom_addr_good_i(rom_addr_good),
		.rom_check_done_o(rom_done), .rom_sig_addr_o(sig_addr), .rom_sig_word_o(sig_word));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// straps held three cycles under reset, then wait for final setting
	task automatic boot(input logic [2:0] dat, clk, fix, chg, prof, input logic [3:0] dp, dm);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		raw = '{dat, clk, fix, chg, prof, dp, dm};
		repeat (3) @(negedge clk_i);
		rst_b_i = 1'b1;
		for (int i = 0; i < 40 && cfg_valid_o !== 1'b1; i++)
			@(negedge clk_i);
		if (cfg_valid_o !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask
	task automatic t_smbus(input int prof, input logic slave);
		boot(lv[4], lv[4], lv[5], lv[2], lv[prof], 4'h5, 4'h6);
		chk("pin_mode", pin_mode_o, 2'h1);
		chk("smbus_slave", smbus_slave_en_o, slave);
		chk("host_sel", host_port_select_o, 2'h3);
		chk("fixed", fixed_port_mask_o, 4'hf);
		chk("charge", charge_port_mask_o, 4'h1);
		chk("port2", port2_disable_o, 4'h4);
		chk("port3", port3_disable_o, 4'h4);
		raw = '{lv[3], lv[0], lv[1], lv[1], lv[4], 4'hf, 4'hf};
		repeat (5) @(negedge clk_i);
		chk("frozen_mode", pin_mode_o, 2'h1);
		chk("frozen_fixed", fixed_port_mask_o, 4'hf);
		chk("frozen_port", port2_disable_o, 4'h4);
	endtask
	task automatic t_uart_levels();
		for (int i = 1; i <= 6; i++) begin
			boot(lv[3], lv[0], lv[(i - 1) % 5 + 1], lv[5 - (i - 1) % 5], lv[i], 4'hf, 4'h0);
			chk("uart_mode", pin_mode_o, 2'h3);
			chk("uart_en", uart_en_o, 1'b1);
			chk("profile", profile_o, i);
			chk("smbus_pins", smbus_pins_en_o, i != 4 && i != 5);
			chk("fixed", fixed_port_mask_o, (1 << ((i - 1) % 5)) - 1);
			chk("charge", charge_port_mask_o, (1 << (4 - (i - 1) % 5)) - 1);
			chk("port2", port2_disable_o, 4'h0);
		end
	endtask
	task automatic t_rom(input logic good, input logic addr_good, input int prof);
		logic ok;
		logic pins;
		rom_good = good;
		rom_addr_good = addr_good;
		ok = good && addr_good;
		pins = prof != 4 && prof != 5;
		boot(lv[0], lv[0], lv[2], lv[2], lv[prof], 4'hf, 4'hf);
		chk("rom_mode", pin_mode_o, ok ? 2'h0 : 2'h2);
		chk("rom_en", rom_en_o, ok);
		chk("i2c_en", i2c_bridge_en_o, !ok && pins);
		chk("smbus_slave", smbus_slave_en_o, 1'b0);
		chk("fixed", fixed_port_mask_o, ok ? 4'h0 : 4'h1);
		chk("charge", charge_port_mask_o, ok ? 4'h0 : 4'h1);
		chk("port2", port2_disable_o, 4'hf);
		chk("port3", port3_disable_o, 4'hf);
	endtask
	initial begin
		t_smbus(1, 1'b1);
		t_smbus(5, 1'b0);
		t_uart_levels();
		t_rom(1'b1, 1'b1, 2);
		t_rom(1'b0, 1'b1, 2);
		t_rom(1'b1, 1'b0, 4);
		give_verdict();
	end
endmodule
